/* File: bench/mod_model.sv */
// Behavioural pair of isolated sigma-delta modulators with free-running clocks
`timescale 1ns/1ps
module mod_model #(
  parameter int HALF_NS = 400
) (
  // Ones density per channel, 0 to 256 out of 256
  input wire logic [8:0] level1,
  input wire logic [8:0] level2,
  // Bitstreams and their clocks
  output logic mod1_clk,
  output logic mod1_data,
  output logic mod2_clk,
  output logic mod2_data
);
  logic [8:0] acc1_q = 9'h000;
  logic [8:0] acc2_q = 9'h000;

  // Modulator clocks run free, also between conversions
  initial begin
    mod1_clk = 1'b0;
    mod1_data = 1'b0;
    forever #(HALF_NS) mod1_clk = ~mod1_clk;
  end
  // Second modulator deliberately out of phase with the first
  initial begin
    mod2_clk = 1'b0;
    mod2_data = 1'b0;
    #(HALF_NS / 3);
    forever #(HALF_NS) mod2_clk = ~mod2_clk;
  end
  // Bit moves on the falling edge, clear of the sampling edge
  always @(negedge mod1_clk) begin
    acc1_q = {1'b0, acc1_q[7:0]} + level1;
    mod1_data = acc1_q[8];
  end
  always @(negedge mod2_clk) begin
    acc2_q = {1'b0, acc2_q[7:0]} + level2;
    mod2_data = acc2_q[8];
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the modulator pre-trigger, offset and fault block
`timescale 1ns/1ps
module tb_top;
  import modfault_pkg::*;
  logic ref_clk, rstn, config_clock, config_data_in, config_latch;
  logic mod1_clk, mod1_data, mod2_clk, mod2_data, convert_start_n, channel_select;
  logic serial_out_line, serial_out_oe, result_valid, overrange_flag, threshold_flag;
  logic [RES_W-1:0] result_data, ra, rb, r, e;
  logic [8:0] level1, level2;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int vcnt = 0;
  int vmark = 0;
  int ts, tl, lv, d, lat;
  logic [7:0] pt_code [4] = '{8'h03, 8'h43, 8'h83, 8'hc3};
  int lo [4] = '{500, 230, 0, 0};
  int hi [4] = '{540, 300, 15, 15};

  modfault_top modfault_top_i (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1),
    .config_clock(config_clock), .config_data_in(config_data_in),
    .config_latch(config_latch), .mod1_clk(mod1_clk), .mod1_data(mod1_data),
    .mod2_clk(mod2_clk), .mod2_data(mod2_data), .convert_start_n(convert_start_n),
    .channel_select(channel_select), .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe), .result_data(result_data),
    .result_valid(result_valid), .overrange_flag(overrange_flag),
    .threshold_flag(threshold_flag));
  mod_model mod_model_i (.level1(level1), .level2(level2), .mod1_clk(mod1_clk),
    .mod1_data(mod1_data), .mod2_clk(mod2_clk), .mod2_data(mod2_data));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // One result pulse expected per conversion consumed by the host
  always @(posedge ref_clk) begin
    if (result_valid === 1'b1) vcnt <= vcnt + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Pins held 5 cycles per phase, above the synchroniser's 4
  task automatic send_cfg(input logic [7:0] b);
    config_latch = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      config_data_in = b[i];
      tick(5);
      config_clock = 1'b1;
      tick(5);
      config_clock = 1'b0;
    end
    tick(5);
    config_latch = 1'b1;
    tick(8);
  endtask

  task automatic conv(input logic ch, output logic [RES_W-1:0] res, output int l);
    channel_select = ch;
    tick(5);
    convert_start_n = 1'b0;
    l = 0;
    while (serial_out_line !== 1'b1 && l < 700) begin
      tick(1);
      l++;
    end
    check("ready_line", serial_out_line, 1'b1);
    check("line_oe", serial_out_oe, 1'b1);
    res = result_data;
    check("valid_pulse", vcnt - vmark, 1);
    vmark = vcnt;
    tick(3);
    convert_start_n = 1'b1;
    tick(8);
    check("oe_released", serial_out_oe, 1'b0);
  endtask

  // Channel 2 conversion squeezed between periodic channel 1 starts
  task automatic periodic(input int n, output int l);
    int t0;
    int l2;
    logic [RES_W-1:0] x;
    for (int k = 0; k < n; k++) begin
      t0 = cyc;
      conv(1'b0, x, l);
      conv(1'b1, x, l2);
      // Back to channel 1, or the tracker may never pre-start
      channel_select = 1'b0;
      while (cyc < t0 + 1600) tick(1);
    end
  endtask

  // Positive when the channel 1 magnitude sits above the level, in mV times 256
  function automatic int thr_margin(input int lvl, input int sel);
    int m;
    m = (2 * lvl - 256) * 320;
    if (m < 0) m = -m;
    return m - (160 + 10 * sel) * 256;
  endfunction

  task automatic close_out();
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    rstn = 1'b0;
    config_clock = 1'b0;
    config_data_in = 1'b0;
    config_latch = 1'b1;
    convert_start_n = 1'b1;
    channel_select = 1'b0;
    level1 = 9'h100;
    level2 = 9'h100;
    void'($urandom(20));
    tick(6);
    rstn = 1'b1;
    tick(5);
    check("ovr_reset", overrange_flag, 1'b0);
    conv(1'b0, ra, lat);
    check("mode0_time", lat >= 500 && lat <= 540, 1'b1);
    level1 = 9'h000;
    conv(1'b0, rb, lat);
    // Calibration at zero input as the host would do it
    send_cfg(8'h58);
    conv(1'b0, r, lat);
    check("cal_raw", r, rb);
    level1 = 9'h100;
    conv(1'b0, r, lat);
    e = ra - rb;
    check("cal_last", r, e);
    send_cfg(8'h50);
    conv(1'b0, r, lat);
    check("offset_ch1", r, 15'h0000);
    conv(1'b1, r, lat);
    check("offset_ch2", r, ra);
    // Every pre-trigger code, bit 6 ignored when bit 7 is set
    for (int m = 0; m < 4; m++) begin
      send_cfg(pt_code[m]);
      periodic(5, lat);
      check("pt_latency", lat >= lo[m] && lat <= hi[m], 1'b1);
    end
    send_cfg(8'h03);
    conv(1'b0, r, lat);
    check("offset_kept", r, 15'h0000);
    // Over-range watched while channel 2 is selected
    channel_select = 1'b1;
    level1 = 9'h080;
    tick(100);
    check("ovr_toggle", overrange_flag, 1'b0);
    level1 = 9'h000;
    tick(160);
    check("ovr_short", overrange_flag, 1'b0);
    tick(80);
    check("ovr_long", overrange_flag, 1'b1);
    level1 = 9'h080;
    tick(30);
    check("ovr_clear", overrange_flag, 1'b0);
    // Random levels, corners first; near-boundary picks pushed clear of quantisation
    for (int i = 0; i < 8; i++) begin
      ts = (i == 0) ? 0 : $urandom_range(3, 0);
      tl = (i == 0) ? 15 : $urandom_range(15, 0);
      lv = (i == 0) ? 0 : $urandom_range(256, 0);
      d = thr_margin(lv, tl);
      if (d > -11520 && d < 11520) lv = (d > 0) ? 0 : 128;
      d = thr_margin(lv, tl);
      // Level first; an old window of up to 128 clocks runs before new settings apply
      level1 = lv[8:0];
      send_cfg({ts[1:0], tl[3:0], 2'b10});
      tick(8 * (128 + 2 * (16 << ts)) + 40);
      check("threshold", threshold_flag, d > 0);
    end
    // Second reset clears the stored offsets
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(5);
    level1 = 9'h100;
    conv(1'b0, r, lat);
    check("offset_reset", r, ra);
    close_out();
  end
endmodule

/* File: hdl/modfault_pkg.sv */
// Shared constants and types for the modulator pre-trigger, offset and fault block
package modfault_pkg;
  // Clock and timing
  localparam int REF_CLK_KHZ = 10000;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * REF_CLK_KHZ + 999999) / 1000000;
  localparam int READY_MAX_NS = 1000;
  localparam int READY_MAX_CYC = (READY_MAX_NS * REF_CLK_KHZ) / 1000000;

  // Input synchroniser vector positions
  localparam int SYN_W = 9;
  localparam int SYN_CFG_CLK = 0;
  localparam int SYN_CFG_DAT = 1;
  localparam int SYN_CFG_LAT = 2;
  localparam int SYN_M1_CLK = 3;
  localparam int SYN_M1_DAT = 4;
  localparam int SYN_M2_CLK = 5;
  localparam int SYN_M2_DAT = 6;
  localparam int SYN_CS_N = 7;
  localparam int SYN_CHANNEL_SELECT = 8;
  // Idle pin levels; convert start and latch idle high, so reset makes no false edge
  localparam logic [SYN_W-1:0] SYN_IDLE = 9'h084;

  // Configuration registers: byte bits 7..2 are stored as bits 5..0
  localparam int CFG_W = 6;
  localparam logic [1:0] ADDR_CONV1 = 2'h0;
  localparam logic [1:0] ADDR_CONV2 = 2'h1;
  localparam logic [1:0] ADDR_THRESH = 2'h2;
  localparam logic [1:0] ADDR_PRETRIG = 2'h3;
  localparam logic [5:0] RST_CONV1 = 6'h30;
  localparam logic [5:0] RST_CONV2 = 6'h30;
  localparam logic [5:0] RST_THRESH = 6'h20;
  localparam logic [5:0] RST_PRETRIG = 6'h00;
  localparam int PT_BIT_HI = 5;
  localparam int PT_BIT_LO = 4;
  localparam int CAL_BIT = 1;
  localparam int THR_TIME_HI = 5;
  localparam int THR_TIME_LO = 4;
  localparam int THR_LVL_HI = 3;
  localparam int THR_LVL_LO = 0;

  // Conversion engine
  localparam int CONV_LEN = 64;
  localparam int POS_W = 6;
  localparam int ACC_W = 12;
  localparam int RES_W = 15;
  localparam int PER_W = 20;

  // Fault detectors
  localparam int OVR_RUN = 25;
  localparam int THR_BASE_MV = 160;
  localparam int THR_STEP_MV = 10;
  localparam int FULL_SCALE_MV = 320;
  localparam int THR_WIN_BASE_LOG2 = 4;
  localparam int THR_CNT_W = 8;

  typedef enum logic [1:0] {PT_OFF = 2'h0, PT_PEAK = 2'h1, PT_END = 2'h3} pt_mode_type;
  typedef enum logic [1:0] {ENG_IDLE = 2'h0, ENG_RUN = 2'h1, ENG_DONE = 2'h3} eng_state_type;
endpackage

/* File: hdl/modfault_top.sv */
// Modulator interface core: pre-trigger tracker, offset calibration, fault detectors
//
// Contract
// RULE1: Mode 0 starts triangular weighting at convert start
// RULE2: Reset selects pre-trigger mode 0
// RULE3: Modes 0/1/2 align start/peak/end to command
// RULE4: Mode 2 gives data within 1 us
// RULE5: Peak-to-ready latency same in every mode
// RULE6: Host issues periodic channel 1 convert starts
// RULE7: Tracker ignores convert starts on channel 2
// RULE8: Register 3 bits 7:6 decode pre-trigger mode
// RULE9: Per-channel offset subtracted from each result
// RULE10: Only reset clears both offset registers
// RULE11: Bit 3 of register 0/1 enables calibration
// RULE12: Calibration stores uncorrected result as offset
// RULE13: Host follows zero-input calibration sequence
// RULE14: Over-range after 25 identical bitstream samples
// RULE15: Fault detectors always watch channel 1
// RULE16: Reduced filter plus comparator drives threshold flag
// RULE17: Register 2 bits 5:2 pick 16 levels
// RULE18: Register 2 bits 7:6 pick detection time
// RULE19: Byte low two bits address, upper six load
// RULE20: Serial line low while busy, high when ready
// RULE21: New settings apply at next conversion boundary
`timescale 1ns/1ps
module modfault_top (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Serial configuration port
  input wire logic config_clock,
  input wire logic config_data_in,
  input wire logic config_latch,
  // Modulator bitstreams and their clocks
  input wire logic mod1_clk,
  input wire logic mod1_data,
  input wire logic mod2_clk,
  input wire logic mod2_data,
  // Host conversion control
  input wire logic convert_start_n,
  input wire logic channel_select,
  // Conversion answer
  output logic serial_out_line,
  output logic serial_out_oe,
  output logic [modfault_pkg::RES_W-1:0] result_data,
  output logic result_valid,
  // Fault outputs
  output logic overrange_flag,
  output logic threshold_flag
);
  import modfault_pkg::*;

  localparam int ReadyBound = READY_MAX_CYC;

  function automatic pt_mode_type decode_pt(input logic [CFG_W-1:0] cfg);
    if (cfg[PT_BIT_HI]) begin
      return PT_END; // [RULE8]
    end
    return cfg[PT_BIT_LO] ? PT_PEAK : PT_OFF; // [RULE8]
  endfunction

  function automatic logic [ACC_W-1:0] weight_of(input logic [POS_W-1:0] pos);
    if (pos < POS_W'(CONV_LEN / 2)) begin
      return ACC_W'(pos) + 1'b1;
    end
    return ACC_W'(CONV_LEN) - ACC_W'(pos);
  endfunction

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [SYN_W-1:0] syn1_q, syn2_q, syn3_q, lvl_q, lvl_prev_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syn1_q <= SYN_IDLE;
      syn2_q <= SYN_IDLE;
      syn3_q <= SYN_IDLE;
      lvl_q <= SYN_IDLE;
      lvl_prev_q <= SYN_IDLE;
    end else if (clk_en) begin
      syn1_q <= {channel_select, convert_start_n, mod2_data, mod2_clk, mod1_data, mod1_clk,
                 config_latch, config_data_in, config_clock};
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
      lvl_prev_q <= lvl_q;
      for (int i = 0; i < SYN_W; i++) begin
        if (syn2_q[i] == syn3_q[i]) begin
          lvl_q[i] <= syn3_q[i];
        end
      end
    end
  end

  logic [SYN_W-1:0] rise;
  assign rise = lvl_q & ~lvl_prev_q;
  logic cs_low, cs_fall, cs_rise, chan2, m1_edge, m2_edge, locked_q, conv_done, thr_hit;
  assign cs_low = !lvl_q[SYN_CS_N];
  assign cs_fall = lvl_prev_q[SYN_CS_N] && !lvl_q[SYN_CS_N];
  assign cs_rise = rise[SYN_CS_N];
  assign chan2 = lvl_q[SYN_CHANNEL_SELECT];
  assign m1_edge = rise[SYN_M1_CLK];
  assign m2_edge = rise[SYN_M2_CLK];

  // Configuration shift register and latch
  logic [7:0] cfg_shift_q;
  logic [CFG_W-1:0] cfg_conv1_q, cfg_conv2_q, cfg_thr_q, cfg_pt_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_shift_q <= 8'h00;
    end else if (clk_en && rise[SYN_CFG_CLK] && !lvl_q[SYN_CFG_LAT]) begin
      cfg_shift_q <= {cfg_shift_q[6:0], lvl_q[SYN_CFG_DAT]};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_conv1_q <= RST_CONV1;
      cfg_conv2_q <= RST_CONV2;
      cfg_thr_q <= RST_THRESH;
      cfg_pt_q <= RST_PRETRIG; // [RULE2]
    end else if (clk_en && rise[SYN_CFG_LAT]) begin
      unique case (cfg_shift_q[1:0]) // [RULE19]
        ADDR_CONV1: cfg_conv1_q <= cfg_shift_q[7:2];
        ADDR_CONV2: cfg_conv2_q <= cfg_shift_q[7:2];
        ADDR_THRESH: cfg_thr_q <= cfg_shift_q[7:2];
        ADDR_PRETRIG: cfg_pt_q <= cfg_shift_q[7:2];
      endcase
    end
  end

  // Settings in force; pre-trigger and calibration refreshed while the engine is idle, threshold at window end
  pt_mode_type pt_act_q;
  logic [1:0] cal_act_q;
  logic [CFG_W-1:0] thr_act_q;
  eng_state_type state_q;
  logic [PER_W-1:0] thr_cnt_q;
  logic thr_win_end;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pt_act_q <= PT_OFF; // [RULE2]
      cal_act_q <= 2'h0;
      thr_act_q <= RST_THRESH;
    end else if (clk_en) begin
      if (state_q == ENG_IDLE) begin
        pt_act_q <= decode_pt(cfg_pt_q); // [RULE21]
        cal_act_q <= {cfg_conv2_q[CAL_BIT], cfg_conv1_q[CAL_BIT]}; // [RULE11] [RULE21]
      end
      if (thr_win_end) begin
        thr_act_q <= cfg_thr_q; // [RULE21]
      end
    end
  end

  // Period tracker for channel 1 convert starts
  logic [PER_W-1:0] phase_q, period_q, dur_q, run_time_q, lead;
  assign lead = (pt_act_q == PT_END) ? dur_q : (dur_q >> 1); // [RULE3]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= '0;
      period_q <= '0;
      locked_q <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall && !chan2) begin // [RULE7]
        period_q <= phase_q + 1'b1;
        locked_q <= (phase_q != '0);
        phase_q <= '0;
      end else if (phase_q != '1) begin
        phase_q <= phase_q + 1'b1;
      end else begin
        locked_q <= 1'b0;
      end
    end
  end

  // Weighted-average conversion engine
  logic [POS_W-1:0] pos_q;
  logic signed [ACC_W-1:0] acc_q;
  logic channel_select_q, seen_q, pre_start, start_now, eng_step, bit_now;
  logic signed [ACC_W-1:0] acc_next;
  logic signed [ACC_W-1:0] offset_q [2];
  assign pre_start = (pt_act_q != PT_OFF) && locked_q && !chan2 && dur_q != '0
                     && period_q > lead && phase_q == period_q - lead; // [RULE3] [RULE6]
  assign start_now = (state_q == ENG_IDLE) && (cs_fall || pre_start); // [RULE1]
  assign eng_step = (state_q == ENG_RUN) && (channel_select_q ? m2_edge : m1_edge);
  assign bit_now = channel_select_q ? lvl_q[SYN_M2_DAT] : lvl_q[SYN_M1_DAT];
  assign acc_next = bit_now ? acc_q + $signed(weight_of(pos_q))
                            : acc_q - $signed(weight_of(pos_q)); // [RULE1]

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ENG_IDLE;
      pos_q <= '0;
      acc_q <= '0;
      channel_select_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (clk_en) begin
      unique case (state_q)
        ENG_IDLE: if (start_now) begin
          state_q <= ENG_RUN;
          pos_q <= '0;
          acc_q <= '0;
          channel_select_q <= chan2;
          seen_q <= cs_fall;
        end
        ENG_RUN: begin
          if (cs_fall) begin
            seen_q <= 1'b1;
          end
          if (cs_rise && seen_q) begin
            state_q <= ENG_IDLE; // Frame cut short by the host
          end else if (eng_step) begin
            acc_q <= acc_next;
            pos_q <= pos_q + 1'b1;
            if (pos_q == POS_W'(CONV_LEN - 1)) begin
              state_q <= ENG_DONE; // [RULE5]
            end
          end
        end
        ENG_DONE: begin
          if (cs_fall) begin
            seen_q <= 1'b1;
          end
          if (cs_rise && seen_q) begin
            state_q <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  // Conversion time learned from channel 1, used as the pre-trigger lead
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_time_q <= '0;
      dur_q <= '0;
    end else if (clk_en) begin
      if (start_now) begin
        run_time_q <= '0;
      end else if (state_q == ENG_RUN && run_time_q != '1) begin
        run_time_q <= run_time_q + 1'b1;
      end
      if (eng_step && pos_q == POS_W'(CONV_LEN - 1) && !channel_select_q) begin
        dur_q <= run_time_q;
      end
    end
  end

  // Offset registers; only the asynchronous reset zeroes them
  assign conv_done = eng_step && pos_q == POS_W'(CONV_LEN - 1);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      offset_q[0] <= '0; // [RULE10]
      offset_q[1] <= '0; // [RULE10]
    end else if (clk_en && conv_done && cal_act_q[channel_select_q]) begin
      offset_q[channel_select_q] <= acc_next; // [RULE12]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_data <= '0;
      result_valid <= 1'b0;
    end else if (clk_en) begin
      result_valid <= conv_done;
      if (conv_done) begin
        result_data <= RES_W'(acc_next) - RES_W'(offset_q[channel_select_q]); // [RULE9]
      end
    end
  end

  // Busy/ready indication on the serial line; driven only while convert start is low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_line <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (clk_en) begin
      serial_out_oe <= cs_low;
      serial_out_line <= cs_low && state_q == ENG_DONE; // [RULE20] [RULE4]
    end
  end

  // Over-range: run length of channel 1 bitstream, whatever the channel select
  logic [4:0] run_q;
  logic last_bit_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= '0;
      last_bit_q <= 1'b0;
      overrange_flag <= 1'b0;
    end else if (clk_en && m1_edge) begin // [RULE15]
      last_bit_q <= lvl_q[SYN_M1_DAT];
      if (lvl_q[SYN_M1_DAT] != last_bit_q) begin
        run_q <= 5'h01;
        overrange_flag <= 1'b0;
      end else begin
        if (run_q != 5'h1f) begin
          run_q <= run_q + 1'b1;
        end
        overrange_flag <= run_q >= 5'(OVR_RUN - 1); // [RULE14]
      end
    end
  end

  // Threshold: integrate-and-dump ones counter, window set by detection time
  logic [PER_W-1:0] thr_ones_q, thr_win, thr_mag, thr_lim;
  assign thr_win = PER_W'(1) << (THR_WIN_BASE_LOG2 + thr_act_q[THR_TIME_HI:THR_TIME_LO]); // [RULE18]
  assign thr_win_end = m1_edge && thr_cnt_q == thr_win - 1'b1;
  assign thr_mag = (thr_ones_q << 1) >= thr_win ? (thr_ones_q << 1) - thr_win
                                                : thr_win - (thr_ones_q << 1);
  assign thr_lim = PER_W'(THR_BASE_MV + THR_STEP_MV * thr_act_q[THR_LVL_HI:THR_LVL_LO]); // [RULE17]
  assign thr_hit = PER_W'(thr_mag * FULL_SCALE_MV) > PER_W'(thr_lim * thr_win); // [RULE16]

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      thr_cnt_q <= '0;
      thr_ones_q <= '0;
      threshold_flag <= 1'b0;
    end else if (clk_en && m1_edge) begin // [RULE15]
      if (thr_win_end) begin
        threshold_flag <= thr_hit; // [RULE16]
        thr_cnt_q <= '0;
        thr_ones_q <= PER_W'(lvl_q[SYN_M1_DAT]);
      end else begin
        thr_cnt_q <= thr_cnt_q + 1'b1;
        thr_ones_q <= thr_ones_q + PER_W'(lvl_q[SYN_M1_DAT]);
      end
    end
  end

  // Checks
  sequence s_ready_request;
    cs_fall && state_q == ENG_DONE;
  endsequence
  a_mode2_fast_ready: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE4]
    clk_en throughout s_ready_request |-> ##[1:ReadyBound] serial_out_line)
    else $error("Pre-completed data not shown in time");
  a_busy_line_low: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE20]
    clk_en && cs_low && state_q == ENG_RUN |=> serial_out_oe && !serial_out_line)
    else $error("Serial line not low while busy");
  a_chan2_no_track: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE7]
    clk_en && cs_fall && chan2 |=> $stable(period_q))
    else $error("Channel 2 start disturbed tracker");
  a_mode0_start: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE1]
    clk_en && cs_fall && state_q == ENG_IDLE |=> state_q == ENG_RUN && pos_q == '0)
    else $error("Conversion did not start at convert start");
  a_cal_store: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE12]
    clk_en && conv_done && cal_act_q[channel_select_q] |=> offset_q[$past(channel_select_q)] == $past(acc_next))
    else $error("Calibration result not stored");
  a_offset_sub: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE9]
    clk_en && conv_done && !cal_act_q[channel_select_q]
      |=> result_valid
          && result_data == (RES_W'($past(acc_next)) - RES_W'(offset_q[$past(channel_select_q)])))
    else $error("Offset not subtracted");
  a_ovr_run_len: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
    clk_en && m1_edge && lvl_q[SYN_M1_DAT] == last_bit_q && run_q == 5'(OVR_RUN - 1)
      |=> overrange_flag)
    else $error("Over-range not flagged at run limit");
  a_ovr_break: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
    clk_en && m1_edge && lvl_q[SYN_M1_DAT] != last_bit_q |=> !overrange_flag)
    else $error("Over-range held after bit change");
  a_settings_frozen: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE21]
    state_q == ENG_RUN ##1 state_q == ENG_RUN |-> $stable(pt_act_q) && $stable(cal_act_q))
    else $error("Settings changed mid-conversion");
  a_fixed_length: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE5]
    $rose(state_q == ENG_DONE) |-> $past(pos_q) == POS_W'(CONV_LEN - 1))
    else $error("Conversion length not fixed");
  a_thr_update: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE16]
    clk_en && thr_win_end |=> threshold_flag == $past(thr_hit))
    else $error("Threshold flag not updated at window end");
endmodule
